// [common/wibfm_defs.svh]
`ifndef WIBFM_DEFS_SVH
`define WIBFM_DEFS_SVH

// -----------------------------------------------------------------------------
// Register offsets (APB byte addresses).
// -----------------------------------------------------------------------------
`define WIBFM_ADDR_CTRL 12'h000
`define WIBFM_ADDR_STATUS 12'h004
`define WIBFM_ADDR_LATCH 12'h008
`define WIBFM_ADDR_STATE 12'h00C

// -----------------------------------------------------------------------------
// Control register fields.
// -----------------------------------------------------------------------------
`define WIBFM_CTRL_SHORT_OFF 0
`define WIBFM_CTRL_SINK_OFF 1
`define WIBFM_CTRL_THERM_OFF 2
`define WIBFM_CTRL_WARN_IRQ 3
`define WIBFM_CTRL_UV_RST 4
`define WIBFM_CTRL_IRQ_REL 5
`define WIBFM_CTRL_RESET 32'h0000_0010

// -----------------------------------------------------------------------------
// Status register fields (write one to clear).
// -----------------------------------------------------------------------------
`define WIBFM_ST_OVERLOAD 0
`define WIBFM_ST_SHORT 1
`define WIBFM_ST_SINK 2
`define WIBFM_ST_WARN 3
`define WIBFM_ST_TSD 4
`define WIBFM_ST_OVP 5
`define WIBFM_ST_W 6

// -----------------------------------------------------------------------------
// Timing and counts.
// -----------------------------------------------------------------------------
`define WIBFM_CLK_MHZ 40
`define WIBFM_SINK_US 20
`define WIBFM_SINK_CYC (`WIBFM_SINK_US * `WIBFM_CLK_MHZ)
`define WIBFM_RESET_TMO_US 200
`define WIBFM_ERR_LIMIT 4'h4

`endif

// [common/wibfm_pkg.sv]
package wibfm_pkg;

   // Device state as seen by the fault manager.
   typedef enum logic [2:0] {
      WIBFM_ACTIVE,
      WIBFM_CLAMP,
      WIBFM_SAFE,
      WIBFM_RESET,
      WIBFM_OFF
   } wibfm_state_e;

endpackage

// [src/wibfm_timer.sv]
`timescale 1ns/1ps
`include "wibfm_defs.svh"

// Counts cycles while run is high and flags when the limit is exceeded.
module wibfm_timer #(
   parameter int LIMIT = 800
)
(
   // Clock and reset.
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   // Control.
   input wire logic i_run,
   // Result.
   output logic o_expired
);

   localparam int CW = $clog2(LIMIT + 2);
   logic [CW-1:0] cnt_r;

   // Counter restarts whenever run drops; it saturates past the limit.
   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         cnt_r <= '0;
      else if (!i_run)
         cnt_r <= '0;
      else if (cnt_r <= CW'(LIMIT))
         cnt_r <= cnt_r + 1'b1;
   end

   assign o_expired = (cnt_r > CW'(LIMIT));

endmodule

// [src/wibfm_core.sv]
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "wibfm_defs.svh"

module wibfm_core
   import wibfm_pkg::*;
#(
   parameter int RESET_TMO_CYC = `WIBFM_RESET_TMO_US * `WIBFM_CLK_MHZ
)
(
   // Clock and reset.
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   // APB slave.
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Comparators from the power stage (asynchronous).
   input wire logic i_hs_overload,
   input wire logic i_ls_overload,
   input wire logic i_short_detect,
   input wire logic i_ls_sink_detect,
   input wire logic i_therm_warn,
   input wire logic i_therm_warn_clear,
   input wire logic i_therm_shutdown,
   input wire logic i_out_above_uv,
   input wire logic i_rails_below_uv,
   input wire logic i_sense_grounded,
   input wire logic i_ovp_detect,
   input wire logic i_wake,
   input wire logic i_light_load,
   input wire logic i_high_voltage,
   input wire logic i_min_time_limit,
   // Power stage controls.
   output logic o_buck_en,
   output logic o_hs_force_off,
   output logic o_ls_force_on,
   output logic o_second_buck_en,
   output logic o_boost_en,
   output logic o_discharge_en,
   output logic o_temp_mon_en,
   output logic o_pulse_skip_allow,
   output logic o_freq_reduce,
   // Microcontroller side.
   output logic o_fault_interrupt_out_b
);

   // -------------------------------------------------------------------------
   // Input synchronisers.
   // -------------------------------------------------------------------------
   localparam int NIN = 15;
   logic [NIN-1:0] in_raw;
   logic [NIN-1:0] sync1_r;
   logic [NIN-1:0] sync2_r;

   assign in_raw = {i_min_time_limit, i_high_voltage, i_light_load, i_wake, i_ovp_detect,
                    i_sense_grounded, i_rails_below_uv, i_out_above_uv, i_therm_shutdown,
                    i_therm_warn_clear, i_therm_warn, i_ls_sink_detect, i_short_detect,
                    i_ls_overload, i_hs_overload};

   // Two flops per comparator, since the stage is asynchronous to the digital clock.
   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         sync1_r <= '0;
         sync2_r <= '0;
      end
      else
      begin
         sync1_r <= in_raw;
         sync2_r <= sync1_r;
      end
   end

   logic s_hs_ovc, s_ls_ovc, s_short, s_sink, s_warn, s_warn_clr, s_tsd;
   logic s_above_uv, s_below_uv, s_sense_gnd, s_ovp, s_wake, s_light, s_hv, s_mintime;
   assign {s_mintime, s_hv, s_light, s_wake, s_ovp, s_sense_gnd, s_below_uv, s_above_uv,
           s_tsd, s_warn_clr, s_warn, s_sink, s_short, s_ls_ovc, s_hs_ovc} = sync2_r;

   // -------------------------------------------------------------------------
   // Registers and bus.
   // -------------------------------------------------------------------------
   logic [31:0] ctrl_r;
   logic [`WIBFM_ST_W-1:0] status_r;
   logic [`WIBFM_ST_W-1:0] latch_r;
   logic [3:0] err_cnt_r;
   wibfm_state_e state_r;
   logic wr_en;
   logic [`WIBFM_ST_W-1:0] st_set;
   logic [`WIBFM_ST_W-1:0] st_clr;

   assign wr_en = i_psel && i_penable && i_pwrite;
   assign o_pready = 1'b1;
   assign o_pslverr = i_psel && i_penable && (i_paddr > `WIBFM_ADDR_STATE || i_paddr[1:0] != 2'h0);

   // Control register: only defined bits are writable.
   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         ctrl_r <= `WIBFM_CTRL_RESET;
      else if (wr_en && i_paddr == `WIBFM_ADDR_CTRL)
         ctrl_r <= {26'h0, i_pwdata[5:0]};
   end

   // Read data is registered in the setup cycle so it is stable in access.
   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         o_prdata <= 32'h0000_0000;
      else if (i_psel && !i_penable && !i_pwrite)
      begin
         unique case (i_paddr)
            `WIBFM_ADDR_CTRL: o_prdata <= ctrl_r;
            `WIBFM_ADDR_STATUS: o_prdata <= {26'h0, status_r};
            `WIBFM_ADDR_LATCH: o_prdata <= {26'h0, latch_r};
            `WIBFM_ADDR_STATE: o_prdata <= {25'h0, err_cnt_r, state_r};
            default: o_prdata <= 32'h0000_0000;
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // Fault detection.
   // -------------------------------------------------------------------------
   logic sink_mask_r;
   logic sink_live;
   logic sink_trip;
   logic short_seen_r;
   logic short_done;
   logic warn_event;
   logic warn_prev_r;
   logic restart_ok_r;
   logic ovp_kill;

   // Sink detection blanked after enable until output first clears UV.
   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         sink_mask_r <= 1'b1;
      else if (!o_buck_en)
         sink_mask_r <= 1'b1;
      else if (s_above_uv)
         sink_mask_r <= 1'b0;
   end

   assign sink_live = s_sink && !sink_mask_r && o_buck_en;

   wibfm_timer #(
      .LIMIT(`WIBFM_SINK_CYC)
   ) u_sink_timer (
      .i_sys_clk(i_sys_clk),
      .i_rst_b(i_rst_b),
      .i_run(sink_live),
      .o_expired(sink_trip)
   );

   // Short clamp: finished once both overload comparators have released.
   assign short_done = state_r == WIBFM_CLAMP && !s_hs_ovc && !s_ls_ovc;
   assign o_hs_force_off = state_r == WIBFM_CLAMP;
   assign o_ls_force_on = state_r == WIBFM_CLAMP;

   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         short_seen_r <= 1'b0;
      else
         short_seen_r <= state_r == WIBFM_CLAMP;
   end

   assign ovp_kill = s_sense_gnd && status_r[`WIBFM_ST_OVP];

   // Restart gate opens only after the warning clears past hysteresis.
   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         restart_ok_r <= 1'b1;
      else if (s_tsd || s_warn)
         restart_ok_r <= 1'b0;
      else if (s_warn_clr)
         restart_ok_r <= 1'b1;
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         warn_prev_r <= 1'b0;
      else
         warn_prev_r <= s_warn && o_temp_mon_en;
   end
   assign warn_event = s_warn && o_temp_mon_en && !warn_prev_r;

   // Sticky flags: a new event wins over a clear in the same cycle.
   always_comb
   begin
      st_set = '0;
      st_set[`WIBFM_ST_OVERLOAD] = o_buck_en && (s_hs_ovc || s_ls_ovc);
      st_set[`WIBFM_ST_SHORT] = short_done;
      st_set[`WIBFM_ST_SINK] = sink_live;
      st_set[`WIBFM_ST_WARN] = s_warn && o_temp_mon_en;
      st_set[`WIBFM_ST_TSD] = s_tsd && o_temp_mon_en;
      st_set[`WIBFM_ST_OVP] = s_ovp;
      st_clr = (wr_en && i_paddr == `WIBFM_ADDR_STATUS) ? i_pwdata[`WIBFM_ST_W-1:0] : '0;
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         status_r <= '0;
      else
         status_r <= (status_r & ~st_clr) | st_set;
   end

   // -------------------------------------------------------------------------
   // Device state machine.
   // -------------------------------------------------------------------------
   logic tsd_hit;
   logic reset_tmo;
   logic to_off;
   logic to_safe;
   logic err_full;

   assign tsd_hit = s_tsd && o_temp_mon_en;
   assign err_full = err_cnt_r >= `WIBFM_ERR_LIMIT;

   assign to_off = (short_done && ctrl_r[`WIBFM_CTRL_SHORT_OFF])
                 || (sink_trip && ctrl_r[`WIBFM_CTRL_SINK_OFF])
                 || (tsd_hit && ctrl_r[`WIBFM_CTRL_THERM_OFF]);
   assign to_safe = (short_done && !ctrl_r[`WIBFM_CTRL_SHORT_OFF])
                  || (sink_trip && !ctrl_r[`WIBFM_CTRL_SINK_OFF])
                  || (tsd_hit && !ctrl_r[`WIBFM_CTRL_THERM_OFF]);

   wibfm_timer #(
      .LIMIT(RESET_TMO_CYC)
   ) u_reset_timer (
      .i_sys_clk(i_sys_clk),
      .i_rst_b(i_rst_b),
      .i_run(state_r == WIBFM_RESET),
      .o_expired(reset_tmo)
   );

   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         state_r <= WIBFM_RESET;
      else
      begin
         unique case (state_r)
            WIBFM_ACTIVE, WIBFM_RESET:
            begin
               if (to_off)
                  state_r <= WIBFM_OFF;
               else if (to_safe)
                  state_r <= err_full ? WIBFM_OFF : WIBFM_SAFE;
               else if (s_short && o_buck_en)
                  state_r <= WIBFM_CLAMP;
               else if (state_r == WIBFM_RESET && reset_tmo)
                  state_r <= WIBFM_OFF;
               else if (state_r == WIBFM_RESET && o_boost_en)
                  state_r <= WIBFM_ACTIVE;
            end
            WIBFM_CLAMP:
            begin
               if (to_off)
                  state_r <= WIBFM_OFF;
               else if (to_safe)
                  state_r <= err_full ? WIBFM_OFF : WIBFM_SAFE;
            end
            WIBFM_SAFE:
               if (s_below_uv && ctrl_r[`WIBFM_CTRL_UV_RST])
                  state_r <= WIBFM_RESET;
            WIBFM_OFF:
               if (s_wake && restart_ok_r)
                  state_r <= WIBFM_RESET;
         endcase
      end
   end

   // Error counter counts every SAFE entry; cleared only by reset.
   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         err_cnt_r <= 4'h0;
      else if (to_safe && state_r != WIBFM_SAFE && state_r != WIBFM_OFF && !err_full)
         err_cnt_r <= err_cnt_r + 4'h1;
   end

   // Latch keeps the reason for an off-select OFF entry until the next reset; limit and timeout OFF entries set no bit.
   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         latch_r <= '0;
      else if (state_r != WIBFM_OFF && state_r != WIBFM_SAFE)
      begin
         if (short_done && ctrl_r[`WIBFM_CTRL_SHORT_OFF])
            latch_r[`WIBFM_ST_SHORT] <= 1'b1;
         if (sink_trip && ctrl_r[`WIBFM_CTRL_SINK_OFF])
            latch_r[`WIBFM_ST_SINK] <= 1'b1;
         if (tsd_hit && ctrl_r[`WIBFM_CTRL_THERM_OFF])
            latch_r[`WIBFM_ST_TSD] <= 1'b1;
      end
   end

   // -------------------------------------------------------------------------
   // Regulator enables and restart sequence.
   // -------------------------------------------------------------------------
   logic running;
   logic second_on_r;

   assign running = state_r == WIBFM_ACTIVE || state_r == WIBFM_RESET;
   // A live critical fault holds the buck off; the cool-down gate only blocks a restart.
   assign o_buck_en = running && !ovp_kill && !tsd_hit && !sink_trip && !short_seen_r
                      && (restart_ok_r || state_r == WIBFM_ACTIVE);

   // Second buck follows buck UV release, boost follows the second buck.
   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         second_on_r <= 1'b0;
         o_boost_en <= 1'b0;
      end
      else if (!o_buck_en)
      begin
         second_on_r <= 1'b0;
         o_boost_en <= 1'b0;
      end
      else
      begin
         if (s_above_uv)
            second_on_r <= 1'b1;
         o_boost_en <= second_on_r;
      end
   end
   assign o_second_buck_en = second_on_r;

   // Discharge only in OFF; SAFE leaves the rails to bleed down.
   assign o_discharge_en = state_r == WIBFM_OFF;
   assign o_temp_mon_en = state_r != WIBFM_OFF;

   // Modulation hints to the analog controller.
   assign o_freq_reduce = o_buck_en && s_mintime;
   assign o_pulse_skip_allow = o_buck_en && (s_light || s_hv);

   // -------------------------------------------------------------------------
   // Interrupt pin: low on SAFE entry or an enabled warning, released by write.
   // -------------------------------------------------------------------------
   logic irq_low_r;

   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         irq_low_r <= 1'b0;
      else if (to_safe && state_r != WIBFM_SAFE)
         irq_low_r <= 1'b1;
      else if (warn_event && ctrl_r[`WIBFM_CTRL_WARN_IRQ] && !irq_low_r)
         irq_low_r <= 1'b1;
      else if (wr_en && i_paddr == `WIBFM_ADDR_CTRL && i_pwdata[`WIBFM_CTRL_IRQ_REL])
         irq_low_r <= 1'b0;
   end
   assign o_fault_interrupt_out_b = !irq_low_r;

   // -------------------------------------------------------------------------
   // Checks.
   // -------------------------------------------------------------------------
   a_safe_irq_low: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (to_safe && state_r == WIBFM_ACTIVE && !err_full) |=> !o_fault_interrupt_out_b)
      else $error("interrupt not driven on safe entry");
   a_off_discharge: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (short_done && ctrl_r[`WIBFM_CTRL_SHORT_OFF]) |=> o_discharge_en && !o_buck_en)
      else $error("short did not reach off with discharge");
   a_clamp_switches: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (s_short && o_buck_en && state_r == WIBFM_ACTIVE && !to_off && !to_safe)
      |=> o_hs_force_off && o_ls_force_on)
      else $error("short did not clamp switches");
   a_sink_masked: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      sink_mask_r |-> !st_set[`WIBFM_ST_SINK])
      else $error("sink flag set while masked");
   a_overload_runs: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (o_buck_en && (s_hs_ovc || s_ls_ovc) && !s_short && !tsd_hit && !sink_trip && !ovp_kill
       && state_r == WIBFM_ACTIVE) |=> status_r[`WIBFM_ST_OVERLOAD] && o_buck_en)
      else $error("overload stopped the regulator");
   a_safe_no_dis: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      state_r == WIBFM_SAFE |-> !o_discharge_en && !o_buck_en && !o_boost_en)
      else $error("safe state left converters or discharge on");
   a_tsd_latched: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (tsd_hit && ctrl_r[`WIBFM_CTRL_THERM_OFF] && running) |=> latch_r[`WIBFM_ST_TSD]
      && state_r == WIBFM_OFF)
      else $error("thermal shutdown not latched");
   a_err_counted: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (to_safe && state_r == WIBFM_ACTIVE && !err_full) |=> err_cnt_r == $past(err_cnt_r) + 4'h1)
      else $error("error counter did not advance");
   a_temp_off: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      state_r == WIBFM_OFF |-> !o_temp_mon_en && !tsd_hit && !st_set[`WIBFM_ST_WARN])
      else $error("temperature monitor active in off");

endmodule

// [testbench/wibfm_stage_model.sv]
`timescale 1ns/1ps

// Power stage model: the output voltage follows the buck enable with a lag.
module wibfm_stage_model #(
   parameter logic [7:0] RISE = 8'h06
)
(
   // Clock and reset.
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   // Stage control.
   input wire logic i_buck_en,
   input wire logic i_stall,
   // Comparator outputs.
   output logic o_out_above_uv,
   output logic o_rails_below_uv
);
   logic [7:0] lvl_r;

   // A stalled stage never reaches regulation, as with a shorted output.
   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         lvl_r <= 8'h00;
      else if (i_buck_en && !i_stall && lvl_r < RISE)
         lvl_r <= lvl_r + 8'h01;
      else if ((!i_buck_en || i_stall) && lvl_r != 8'h00)
         lvl_r <= lvl_r - 8'h01;
   end

   // Thresholds sit at the top and near the bottom of the ramp.
   assign o_out_above_uv = (lvl_r == RISE);
   assign o_rails_below_uv = (lvl_r < 8'h02);
endmodule

// [testbench/test_wide_input_buck_fault_manager.sv]
`timescale 1ns/1ps
`include "wibfm_defs.svh"

module test_wide_input_buck_fault_manager
   import wibfm_pkg::*;
;
   typedef struct {logic [31:0] ctrl; logic [1:0] kind; wibfm_state_e st;
      logic [31:0] fb;} wibfm_row_s;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, q;
   logic pready, serr, pslverr, off;
   logic hs_ov = 0, ls_ov = 0, shrt = 0, sink = 0, warn = 0, wclr = 0, tsd = 0;
   logic sgnd = 0, ovp = 0, wake = 0, light = 0, hv = 0, mint = 0, stall = 0;
   logic above, below, buck, hsoff, lson, b2, bst, dis, tmon, skip, fred, irq_b;
   int err_count = 0, check_count = 0, k;
   wibfm_row_s r;
   wibfm_row_s rows[6] = '{'{32'h01, 2'd0, WIBFM_OFF, 32'h02}, '{32'h00, 2'd0, WIBFM_SAFE, 32'h02},
      '{32'h02, 2'd1, WIBFM_OFF, 32'h04}, '{32'h00, 2'd1, WIBFM_SAFE, 32'h04},
      '{32'h04, 2'd2, WIBFM_OFF, 32'h10}, '{32'h00, 2'd2, WIBFM_SAFE, 32'h10}};

   // A 25 ns period gives the 40 MHz system clock.
   always #12.5 clk = ~clk;

   wibfm_core #(.RESET_TMO_CYC(20)) u_dut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_hs_overload(hs_ov),
      .i_ls_overload(ls_ov), .i_short_detect(shrt), .i_ls_sink_detect(sink),
      .i_therm_warn(warn), .i_therm_warn_clear(wclr), .i_therm_shutdown(tsd),
      .i_out_above_uv(above), .i_rails_below_uv(below), .i_sense_grounded(sgnd),
      .i_ovp_detect(ovp), .i_wake(wake), .i_light_load(light), .i_high_voltage(hv),
      .i_min_time_limit(mint), .o_buck_en(buck), .o_hs_force_off(hsoff), .o_ls_force_on(lson),
      .o_second_buck_en(b2), .o_boost_en(bst), .o_discharge_en(dis), .o_temp_mon_en(tmon),
      .o_pulse_skip_allow(skip), .o_freq_reduce(fred), .o_fault_interrupt_out_b(irq_b));

   wibfm_stage_model u_stage (.i_sys_clk(clk), .i_rst_b(rst_b), .i_buck_en(buck),
      .i_stall(stall), .o_out_above_uv(above), .o_rails_below_uv(below));

   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e)
      begin
         $display("ERROR %s expected %h seen %h", n, e, s);
         err_count++;
      end
   endtask

   // One APB transfer; the request stands until pready is seen high.
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      q = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Waits for a restart; the second buck must lead the boost by one edge.
   task wait_up;
      for (k = 0; k < 300 && b2 !== 1'b1; k++) @(negedge clk);
      chk("b2_up", b2, 1);
      chk("bst_lag", bst, 0);
      @(negedge clk);
      chk("bst_up", bst, 1);
      @(posedge clk);
   endtask

   task rst(input logic up);
      rst_b <= 1'b0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      if (up)
         wait_up;
   endtask

   task inject(input logic [1:0] kd);
      if (kd == 2'd0)
      begin
         shrt <= 1'b1;
         hs_ov <= 1'b1;
         repeat (6) @(posedge clk);
         @(negedge clk);
         chk("hs_off", hsoff, 1);
         chk("ls_on", lson, 1);
         @(posedge clk);
         shrt <= 1'b0;
         hs_ov <= 1'b0;
      end
      else
      begin
         sink <= (kd == 2'd1);
         tsd <= (kd == 2'd2);
         repeat ((kd == 2'd1) ? 900 : 6) @(posedge clk);
         sink <= 1'b0;
         tsd <= 1'b0;
      end
      repeat (4) @(posedge clk);
   endtask

   task print_verdict;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Watchdog; the whole sequence needs well under 20000 cycles.
   initial
   begin
      repeat (30000) @(posedge clk);
      err_count++;
      print_verdict;
   end

   initial
   begin
      rst(1'b1);
      apb(1'b0, `WIBFM_ADDR_CTRL, 0);
      chk("ctrl_rst", q, `WIBFM_CTRL_RESET);
      apb(1'b0, 12'h010, 0);
      chk("unmapped_err", serr, 1);
      chk("unmapped_data", q, 0);
      // Each fault kind under both settings of its off-select bit.
      foreach (rows[i])
      begin
         r = rows[i];
         off = (r.st == WIBFM_OFF);
         rst(1'b1);
         apb(1'b1, `WIBFM_ADDR_CTRL, r.ctrl);
         inject(r.kind);
         repeat (8) @(posedge clk);
         @(negedge clk);
         chk("irq", irq_b, off);
         chk("dis", dis, off);
         chk("conv", {buck, b2, bst}, 0);
         chk("tmon", tmon, !off);
         apb(1'b0, `WIBFM_ADDR_STATE, 0);
         chk("state", q[2:0], r.st);
         chk("errcnt", q[6:3], !off);
         apb(1'b0, `WIBFM_ADDR_STATUS, 0);
         chk("flag", q & r.fb, r.fb);
         apb(1'b0, `WIBFM_ADDR_LATCH, 0);
         chk("latch", q, off ? r.fb : 0);
         $display("row %0d done", i);
      end
      // Overload keeps the regulator on; status clears by writing one.
      rst(1'b1);
      ls_ov <= 1'b1;
      repeat (4) @(posedge clk);
      ls_ov <= 1'b0;
      repeat (4) @(posedge clk);
      chk("ovl_on", buck, 1);
      apb(1'b0, `WIBFM_ADDR_STATUS, 0);
      chk("ovl_flag", q, 32'h01);
      apb(1'b1, `WIBFM_ADDR_STATUS, 32'h01);
      apb(1'b0, `WIBFM_ADDR_STATUS, 0);
      chk("ovl_w1c", q, 0);
      // Thermal warning pulls the pin low only when enabled at the crossing.
      warn <= 1'b1;
      repeat (6) @(posedge clk);
      chk("warn_mask", irq_b, 1);
      chk("warn_run", buck, 1);
      warn <= 1'b0;
      apb(1'b1, `WIBFM_ADDR_CTRL, 32'h18);
      warn <= 1'b1;
      repeat (4) @(posedge clk);
      chk("warn_irq", irq_b, 0);
      // Cooling below the hysteresis point re-arms the restart gate.
      warn <= 1'b0;
      wclr <= 1'b1;
      apb(1'b1, `WIBFM_ADDR_CTRL, 32'h38);
      repeat (2) @(posedge clk);
      chk("irq_rel", irq_b, 1);
      wclr <= 1'b0;
      $display("overload and warning done");
      // Repeated shorts restart until the error counter limit turns it off.
      for (int n = 0; n < 5; n++)
      begin
         inject(2'd0);
         if (n < 4)
            wait_up;
      end
      repeat (12) @(posedge clk);
      apb(1'b0, `WIBFM_ADDR_STATE, 0);
      chk("limit", q[6:0], {4'h4, 3'(WIBFM_OFF)});
      $display("restart limit done");
      // Restart from thermal off waits for the temperature to cool down.
      rst(1'b1);
      apb(1'b1, `WIBFM_ADDR_CTRL, 32'h04);
      inject(2'd2);
      wake <= 1'b1;
      repeat (10) @(posedge clk);
      apb(1'b0, `WIBFM_ADDR_STATE, 0);
      chk("hot_off", q[2:0], WIBFM_OFF);
      wclr <= 1'b1;
      wait_up;
      chk("tmon_wake", tmon, 1);
      wake <= 1'b0;
      wclr <= 1'b0;
      // A stage that never regulates ends in OFF after the reset timeout.
      stall <= 1'b1;
      rst(1'b0);
      repeat (40) @(posedge clk);
      apb(1'b0, `WIBFM_ADDR_STATE, 0);
      chk("rst_tmo", q[2:0], WIBFM_OFF);
      stall <= 1'b0;
      $display("thermal and timeout done");
      // Grounded sense with protection flag disables the buck.
      rst(1'b1);
      sgnd <= 1'b1;
      ovp <= 1'b1;
      repeat (6) @(posedge clk);
      chk("sense_gnd", buck, 0);
      sgnd <= 1'b0;
      ovp <= 1'b0;
      // Every combination of the frequency and pulse-skip inputs.
      for (int v = 0; v < 8; v++)
      begin
         {mint, hv, light} <= 3'(v);
         repeat (4) @(posedge clk);
         chk("skip", skip, v[0] | v[1]);
         chk("freq", fred, v[2]);
      end
      $display("sense and mode done");
      print_verdict;
   end
endmodule
